//--- verilog/crtc_top.sv
`timescale 1ns/1ps
`default_nettype none
module crtc_top #(
   parameter int unsigned QUARTER_CYCLES = crtc_pkg::QUARTER_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic        low_speed_mode,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             clk_out
);

   localparam int                          QW        = crtc_pkg::QCNT_W;
   localparam logic [crtc_pkg::QCNT_W-1:0] QCNT_LAST = QW'(QUARTER_CYCLES - 1);

   crtc_pkg::crtc_state_t q;
   crtc_pkg::crtc_state_t d;

   logic       calendar;
   logic       qtick;
   logic       frc_tick;
   logic       fire;
   logic       wr;
   logic       setup;
   logic       mapped;
   logic [7:0] ev;
   logic [7:0] clr;
   logic [8:0] s_inc;
   logic [8:0] m_inc;
   logic [8:0] h_inc;
   logic [1:0] src;

   always_comb begin
      d        = q;
      ev       = crtc_pkg::ZERO8;
      clr      = crtc_pkg::ZERO8;
      src      = q.css[crtc_pkg::CSS_SRC_LO +: 2];
      calendar = (src == crtc_pkg::SRC_WATCH);
      setup    = psel & ~penable;
      fire     = psel & penable & q.ready;
      wr       = fire & pwrite;
      qtick    = calendar & q.run & (q.qcnt == QCNT_LAST);
      // free count gated by run, halts in low speed
      frc_tick = ~calendar & q.run & ~q.lsm_s & ((q.pre & crtc_pkg::crtc_frc_mask(src)) == crtc_pkg::ZERO8);
      s_inc    = crtc_pkg::crtc_bcd_inc(q.sec, crtc_pkg::SEC_MAX);
      m_inc    = crtc_pkg::crtc_bcd_inc(q.min, crtc_pkg::MIN_MAX);
      h_inc    = crtc_pkg::crtc_bcd_inc(q.hr, q.h24 ? crtc_pkg::HR24_MAX : crtc_pkg::HR12_MAX);

      d.lsm_m = low_speed_mode;
      d.lsm_s = q.lsm_m;
      d.pre   = q.pre + 8'h01;

      // Quarter-second base; calendar keeps running in low speed
      if (calendar & q.run) begin
         d.qcnt = qtick ? '0 : q.qcnt + QW'(1);
      end

      if (qtick) begin
         ev[crtc_pkg::FLG_QTR] = 1'b1;
         d.qph = q.qph + 2'h1;
         if (q.qph[0]) begin
            ev[crtc_pkg::FLG_HALF] = 1'b1;
         end
         if (q.qph == 2'h3) begin
            ev[crtc_pkg::FLG_SEC] = 1'b1;
            d.sec = s_inc[7:0];
            if (s_inc[8]) begin
               ev[crtc_pkg::FLG_MIN] = 1'b1;
               d.min = m_inc[7:0];
               if (m_inc[8]) begin
                  ev[crtc_pkg::FLG_HOUR] = 1'b1;
                  d.hr = h_inc[7:0];
                  if (h_inc[8]) begin
                     ev[crtc_pkg::FLG_DAY] = 1'b1;
                     if (q.wk >= crtc_pkg::WK_MAX) begin
                        d.wk = 3'h0;
                        ev[crtc_pkg::FLG_WEEK] = 1'b1;
                     end else begin
                        d.wk = q.wk + 3'h1;
                     end
                  end
               end
            end
         end
      end

      if (frc_tick) begin
         d.sec = q.sec + 8'h01;
         if (q.sec == crtc_pkg::FRC_MAX) begin
            ev[crtc_pkg::FLG_OVF] = 1'b1;
         end
      end

      // Register writes land at the access edge
      if (wr) begin
         unique case (paddr)
            crtc_pkg::OFF_SEC: d.sec = pwdata[7:0];
            crtc_pkg::OFF_MIN: d.min = pwdata[7:0];
            crtc_pkg::OFF_HR:  d.hr = pwdata[7:0];
            crtc_pkg::OFF_WK:  d.wk = pwdata[2:0];
            crtc_pkg::OFF_CC1: begin
               d.run = pwdata[crtc_pkg::CC1_RUN];
               d.h24 = pwdata[crtc_pkg::CC1_H24];
               if (pwdata[crtc_pkg::CC1_RST]) begin
                  d.sec  = crtc_pkg::ZERO8;
                  d.min  = crtc_pkg::ZERO8;
                  d.hr   = crtc_pkg::ZERO8;
                  d.wk   = 3'h0;
                  d.qcnt = '0;
                  d.qph  = 2'h0;
               end
            end
            crtc_pkg::OFF_CC2: d.ctl2 = pwdata[7:0];
            crtc_pkg::OFF_CSS: d.css = pwdata[6:0];
            crtc_pkg::OFF_FLG: clr = ~pwdata[7:0];
            crtc_pkg::OFF_IE1: d.ie1 = pwdata[crtc_pkg::IE1_CLK];
            crtc_pkg::OFF_CLR: clr = pwdata[7:0];
            default: clr = crtc_pkg::ZERO8;
         endcase
      end

      // enabled events set sticky flags; set beats clear
      d.flags = (q.flags & ~clr) | (ev & q.ctl2);
      d.irq = d.ie1 & ((d.flags & d.ctl2) != crtc_pkg::ZERO8);

      // divided clock, off in low-speed mode
      if (q.css[crtc_pkg::CSS_CKO_EN] & ~q.lsm_s) begin
         if ((q.pre & crtc_pkg::crtc_cko_mask(q.css[crtc_pkg::CSS_CKO_LO +: 2])) ==
             crtc_pkg::crtc_cko_mask(q.css[crtc_pkg::CSS_CKO_LO +: 2])) begin
            d.cko = ~q.cko;
         end
      end else begin
         d.cko = 1'b0;
      end

      // APB: answer with no wait state, data prepared in setup
      mapped = (paddr <= crtc_pkg::OFF_CLR) & (paddr[1:0] == 2'h0);
      d.ready  = setup;
      d.slverr = setup & ~mapped;
      d.rdata  = 32'h0000_0000;
      if (setup & ~pwrite) begin
         unique case (paddr)
            crtc_pkg::OFF_SEC: d.rdata = {24'h00_0000, q.sec};
            crtc_pkg::OFF_MIN: d.rdata = {24'h00_0000, q.min};
            crtc_pkg::OFF_HR:  d.rdata = {24'h00_0000, q.hr};
            crtc_pkg::OFF_WK:  d.rdata = {29'h0000_0000, q.wk};
            crtc_pkg::OFF_CC1: d.rdata = {30'h0000_0000, q.h24, q.run};
            crtc_pkg::OFF_CC2: d.rdata = {24'h00_0000, q.ctl2};
            crtc_pkg::OFF_CSS: d.rdata = {25'h000_0000, q.css};
            crtc_pkg::OFF_FLG: d.rdata = {24'h00_0000, q.flags};
            crtc_pkg::OFF_IE1: d.rdata = {31'h0000_0000, q.ie1};
            default: d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign prdata  = q.rdata;
   assign pready  = q.ready;
   assign pslverr = q.slverr;
   assign irq     = q.irq;
   assign clk_out = q.cko;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_sec_bcd;
      (calendar && !wr && q.sec <= crtc_pkg::SEC_MAX && q.sec[3:0] <= crtc_pkg::BCD_NINE) |=>
         (q.sec <= crtc_pkg::SEC_MAX) && (q.sec[3:0] <= crtc_pkg::BCD_NINE);
   endproperty
   a_sec_bcd: assert property (p_sec_bcd) else $error("seconds out of BCD range");

   property p_min_carry;
      (qtick && q.qph == 2'h3 && q.sec == crtc_pkg::SEC_MAX && !wr) |=>
         (q.sec == crtc_pkg::ZERO8) && (q.min != $past(q.min));
   endproperty
   a_min_carry: assert property (p_min_carry) else $error("minute carry missed");

   property p_hr_range;
      (calendar && !q.h24 && !wr && q.hr <= crtc_pkg::HR12_MAX) |=> (q.hr <= crtc_pkg::HR12_MAX);
   endproperty
   a_hr_range: assert property (p_hr_range) else $error("hours out of range");

   property p_wk_wrap;
      (ev[crtc_pkg::FLG_DAY] && q.wk == crtc_pkg::WK_MAX && !wr) ##1 1'b1 |-> q.wk == 3'h0;
   endproperty
   a_wk_wrap: assert property (p_wk_wrap) else $error("weekday did not wrap");

   property p_stop_holds;
      (!q.run && !wr) |=> $stable(q.sec) && $stable(q.min);
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped");

   property p_flag_enabled;
      1'b1 |=> ((q.flags & ~$past(q.flags) & ~$past(q.ctl2)) == crtc_pkg::ZERO8);
   endproperty
   a_flag_enabled: assert property (p_flag_enabled) else $error("disabled flag set");

   property p_frc_read;
      (setup && !pwrite && paddr == crtc_pkg::OFF_SEC && !calendar) |=> prdata[7:0] == $past(q.sec);
   endproperty
   a_frc_read: assert property (p_frc_read) else $error("free count read wrong");

   property p_ovf_irq;
      (frc_tick && q.sec == crtc_pkg::FRC_MAX && q.ctl2[crtc_pkg::FLG_OVF] && q.ie1 && !wr) |=>
         q.flags[crtc_pkg::FLG_OVF] && irq;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

   property p_flag_sticky;
      !(wr && (paddr == crtc_pkg::OFF_FLG || paddr == crtc_pkg::OFF_CLR)) |=>
         ((q.flags & $past(q.flags)) == $past(q.flags));
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

   property p_one_keeps;
      (wr && paddr == crtc_pkg::OFF_FLG) |=>
         ((q.flags & $past(q.flags) & $past(pwdata[7:0])) == ($past(q.flags) & $past(pwdata[7:0])));
   endproperty
   a_one_keeps: assert property (p_one_keeps) else $error("write one cleared flag");

   property p_irq_gate;
      irq |-> q.ie1 && ((q.flags & q.ctl2) != crtc_pkg::ZERO8);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

   property p_frc_halt;
      (!calendar && q.lsm_s && !wr) |=> $stable(q.sec);
   endproperty
   a_frc_halt: assert property (p_frc_halt) else $error("free counter ran in low speed");

   property p_cko_off;
      (!q.css[crtc_pkg::CSS_CKO_EN] || q.lsm_s) |=> !clk_out;
   endproperty
   a_cko_off: assert property (p_cko_off) else $error("clock out while disabled");

   c_min_carry: cover property (qtick && q.qph == 2'h3 && q.sec == crtc_pkg::SEC_MAX);
   c_ovf: cover property (frc_tick && q.sec == crtc_pkg::FRC_MAX);
   c_irq: cover property ($rose(irq));
   c_clr: cover property (wr && paddr == crtc_pkg::OFF_FLG && q.flags != crtc_pkg::ZERO8);

endmodule
`default_nettype wire

//--- verilog/crtc_pkg.sv
`default_nettype none
package crtc_pkg;

   // Timing of the calendar quarter-second base at the 100 MHz bus clock
   localparam int unsigned CLK_KHZ     = 100000;
   localparam int unsigned QUARTER_MS  = 250;
   localparam int unsigned QUARTER_CYC = QUARTER_MS * CLK_KHZ;
   localparam int unsigned QCNT_W      = 25;

   // Register byte offsets
   localparam logic [7:0] OFF_SEC  = 8'h00;
   localparam logic [7:0] OFF_MIN  = 8'h04;
   localparam logic [7:0] OFF_HR   = 8'h08;
   localparam logic [7:0] OFF_WK   = 8'h0C;
   localparam logic [7:0] OFF_CC1  = 8'h10;
   localparam logic [7:0] OFF_CC2  = 8'h14;
   localparam logic [7:0] OFF_CSS  = 8'h18;
   localparam logic [7:0] OFF_FLG  = 8'h1C;
   localparam logic [7:0] OFF_IE1  = 8'h20;
   localparam logic [7:0] OFF_CLR  = 8'h24;

   // clock_control_one bits
   localparam int CC1_RUN = 0;
   localparam int CC1_H24 = 1;
   localparam int CC1_RST = 2;

   // Event, flag and enable bit positions (same layout everywhere)
   localparam int FLG_QTR  = 0;
   localparam int FLG_HALF = 1;
   localparam int FLG_SEC  = 2;
   localparam int FLG_MIN  = 3;
   localparam int FLG_HOUR = 4;
   localparam int FLG_DAY  = 5;
   localparam int FLG_WEEK = 6;
   localparam int FLG_OVF  = 7;

   // clock_source_select fields
   localparam int CSS_SRC_LO = 0;
   localparam int CSS_CKO_LO = 4;
   localparam int CSS_CKO_EN = 6;
   localparam logic [1:0] SRC_WATCH = 2'h0;

   localparam int IE1_CLK = 0;

   // Counter limits and reset values
   localparam logic [7:0] SEC_MAX  = 8'h59;
   localparam logic [7:0] MIN_MAX  = 8'h59;
   localparam logic [7:0] HR12_MAX = 8'h11;
   localparam logic [7:0] HR24_MAX = 8'h23;
   localparam logic [2:0] WK_MAX   = 3'h6;
   localparam logic [7:0] FRC_MAX  = 8'hFF;
   localparam logic [7:0] ZERO8    = 8'h00;
   localparam logic [3:0] BCD_NINE = 4'h9;

   typedef struct packed {
      logic [7:0]        sec;
      logic [7:0]        min;
      logic [7:0]        hr;
      logic [2:0]        wk;
      logic              run;
      logic              h24;
      logic [7:0]        ctl2;
      logic [6:0]        css;
      logic [7:0]        flags;
      logic              ie1;
      logic [QCNT_W-1:0] qcnt;
      logic [1:0]        qph;
      logic [7:0]        pre;
      logic              lsm_m;
      logic              lsm_s;
      logic [31:0]       rdata;
      logic              ready;
      logic              slverr;
      logic              irq;
      logic              cko;
   } crtc_state_t;

   // Returns {wrap, next} for a BCD count that wraps after max
   function automatic logic [8:0] crtc_bcd_inc(input logic [7:0] v, input logic [7:0] max);
      logic [8:0] r;
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
      if (v == max) begin
         r = {1'b1, ZERO8};
      end else if (v[3:0] == BCD_NINE) begin
         r = {1'b0, v[7:4] + 4'h1, 4'h0};
      end
      return r;
   endfunction

   // Prescaler mask for the free-running count rate: pclk/4, /16, /64
   function automatic logic [7:0] crtc_frc_mask(input logic [1:0] src);
      logic [7:0] m;
      m = 8'h03;
      unique case (src)
         2'h1: m = 8'h03;
         2'h2: m = 8'h0F;
         2'h3: m = 8'h3F;
         default: m = 8'h03;
      endcase
      return m;
   endfunction

   // Half-period mask for the clock output: pclk/32, /16, /8, /4
   function automatic logic [7:0] crtc_cko_mask(input logic [1:0] sel);
      logic [7:0] m;
      m = 8'h0F;
      unique case (sel)
         2'h0: m = 8'h0F;
         2'h1: m = 8'h07;
         2'h2: m = 8'h03;
         2'h3: m = 8'h01;
      endcase
      return m;
   endfunction

endpackage
`default_nettype wire

//--- bench/tb_crtc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_crtc_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        low_speed_mode;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        clk_out;
   int          err_total;
   int          total_checks;
   logic [31:0] rd;
   logic        serr;
   logic [31:0] a;
   logic        acc;
   int          per;

   crtc_top #(.QUARTER_CYCLES(4)) u_dut (
      .pclk           (pclk),
      .presetn        (presetn),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .low_speed_mode (low_speed_mode),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .irq            (irq),
      .clk_out        (clk_out)
   );

   always #5 pclk = ~pclk;

   task automatic report_and_stop();
      $display("errors %0d checks %0d", err_total, total_checks);
      if (err_total == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= addr;
      pwrite  <= wr;
      pwdata  <= data;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd   = prdata;
      serr = pslverr;
      check(32'(n < 50), 32'h1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_flag(input int b, input int lim);
      int n;
      n = 0;
      do begin
         apb(1'b0, crtc_pkg::OFF_FLG, 32'h0);
         n++;
      end while (rd[b] !== 1'b1 && n < lim);
   endtask

   // Period of clk_out in pclk cycles, rise to rise
   task automatic measure(output int p);
      for (int k = 0; k < 2; k++) begin
         p = 0;
         do begin
            @(posedge pclk);
            p++;
         end while (clk_out !== 1'b0 && p < 100);
         do begin
            @(posedge pclk);
            p++;
         end while (clk_out !== 1'b1 && p < 100);
      end
   endtask

   task automatic hold_test(input logic same);
      apb(1'b0, crtc_pkg::OFF_SEC, 32'h0);
      a = rd;
      repeat (40) @(posedge pclk);
      apb(1'b0, crtc_pkg::OFF_SEC, 32'h0);
      check(32'(rd === a), 32'(same));
   endtask

   initial begin
      #400000;
      err_total++;
      report_and_stop();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      low_speed_mode = 1'b0;
      err_total = 0;
      total_checks = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check(rd, 32'h0);
      end
      apb(1'b0, 8'h28, 32'h0);
      check({serr, rd[30:0]}, 32'h80000000);
      // 12-hour calendar wrapping at every level
      apb(1'b1, crtc_pkg::OFF_SEC, 32'h58);
      apb(1'b1, crtc_pkg::OFF_MIN, 32'h59);
      apb(1'b1, crtc_pkg::OFF_HR, 32'h11);
      apb(1'b1, crtc_pkg::OFF_WK, 32'h6);
      apb(1'b1, crtc_pkg::OFF_CC2, 32'h7F);
      apb(1'b1, crtc_pkg::OFF_IE1, 32'h1);
      apb(1'b1, crtc_pkg::OFF_CC1, 32'h1);
      wait_flag(crtc_pkg::FLG_MIN, 60);
      apb(1'b1, crtc_pkg::OFF_CC1, 32'h0);
      apb(1'b0, crtc_pkg::OFF_SEC, 32'h0);
      check(rd, 32'h00);
      apb(1'b0, crtc_pkg::OFF_MIN, 32'h0);
      check(rd, 32'h00);
      apb(1'b0, crtc_pkg::OFF_HR, 32'h0);
      check(rd, 32'h00);
      apb(1'b0, crtc_pkg::OFF_WK, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, crtc_pkg::OFF_FLG, 32'h0);
      check(rd & 32'h78, 32'h78);
      check(32'(irq), 32'h1);
      apb(1'b1, crtc_pkg::OFF_IE1, 32'h0);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0);
      apb(1'b1, crtc_pkg::OFF_FLG, 32'hF7);
      apb(1'b0, crtc_pkg::OFF_FLG, 32'h0);
      check(rd & 32'h78, 32'h70);
      apb(1'b1, crtc_pkg::OFF_CLR, 32'hFF);
      apb(1'b0, crtc_pkg::OFF_FLG, 32'h0);
      check(rd, 32'h0);
      // 24-hour format in low-speed mode
      @(posedge pclk);
      low_speed_mode <= 1'b1;
      apb(1'b1, crtc_pkg::OFF_CC1, 32'h2);
      apb(1'b1, crtc_pkg::OFF_HR, 32'h23);
      apb(1'b1, crtc_pkg::OFF_MIN, 32'h59);
      apb(1'b1, crtc_pkg::OFF_SEC, 32'h59);
      apb(1'b1, crtc_pkg::OFF_CC2, 32'h20);
      apb(1'b1, crtc_pkg::OFF_CC1, 32'h3);
      wait_flag(crtc_pkg::FLG_DAY, 60);
      apb(1'b1, crtc_pkg::OFF_CC1, 32'h2);
      apb(1'b0, crtc_pkg::OFF_HR, 32'h0);
      check(rd, 32'h00);
      apb(1'b0, crtc_pkg::OFF_WK, 32'h0);
      check(rd, 32'h1);
      apb(1'b0, crtc_pkg::OFF_FLG, 32'h0);
      check(rd, 32'h20);
      apb(1'b1, crtc_pkg::OFF_CLR, 32'hFF);
      apb(1'b1, crtc_pkg::OFF_HR, 32'h11);
      apb(1'b1, crtc_pkg::OFF_MIN, 32'h59);
      apb(1'b1, crtc_pkg::OFF_SEC, 32'h59);
      apb(1'b1, crtc_pkg::OFF_CC2, 32'h10);
      apb(1'b1, crtc_pkg::OFF_CC1, 32'h3);
      wait_flag(crtc_pkg::FLG_HOUR, 60);
      apb(1'b1, crtc_pkg::OFF_CC1, 32'h2);
      apb(1'b0, crtc_pkg::OFF_HR, 32'h0);
      check(rd, 32'h12);
      apb(1'b1, crtc_pkg::OFF_CC1, 32'h4);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check(rd, 32'h0);
      end
      // Free-running counter
      low_speed_mode <= 1'b0;
      apb(1'b1, crtc_pkg::OFF_CLR, 32'hFF);
      apb(1'b1, crtc_pkg::OFF_CSS, 32'h1);
      apb(1'b1, crtc_pkg::OFF_CC2, 32'h84);
      apb(1'b1, crtc_pkg::OFF_IE1, 32'h1);
      apb(1'b1, crtc_pkg::OFF_CC1, 32'h1);
      wait_flag(crtc_pkg::FLG_OVF, 600);
      check(rd, 32'h80);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h1);
      hold_test(1'b0);
      low_speed_mode <= 1'b1;
      repeat (4) @(posedge pclk);
      hold_test(1'b1);
      low_speed_mode <= 1'b0;
      apb(1'b1, crtc_pkg::OFF_CC1, 32'h0);
      repeat (4) @(posedge pclk);
      hold_test(1'b1);
      // Slower prescaler rates, reads 256 cycles apart
      for (int s = 2; s < 4; s++) begin
         apb(1'b1, crtc_pkg::OFF_CSS, 32'(s));
         apb(1'b1, crtc_pkg::OFF_CC1, 32'h1);
         apb(1'b0, crtc_pkg::OFF_SEC, 32'h0);
         a = rd;
         repeat (253) @(posedge pclk);
         apb(1'b0, crtc_pkg::OFF_SEC, 32'h0);
         check((rd - a) & 32'hFF, 32'h100 >> (2 * s));
         apb(1'b1, crtc_pkg::OFF_CC1, 32'h0);
      end
      // Divided clock output
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, crtc_pkg::OFF_CSS, 32'h40 | 32'(s << 4));
         measure(per);
         check(32'(per), 32'd32 >> s);
      end
      low_speed_mode <= 1'b1;
      repeat (4) @(posedge pclk);
      acc = 1'b0;
      repeat (40) begin
         @(posedge pclk);
         acc = acc | clk_out;
      end
      check(32'(acc), 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
